// ---- common/dppc_params.svh ----
// Timing constants and reset values for the downstream port power control block.
// Assumes a single 40 MHz hub core clock; every count is derived from it.
`ifndef DPPC_PARAMS_SVH
`define DPPC_PARAMS_SVH

// Core clock period in nanoseconds.
`define DPPC_CLK_PERIOD_NS 25
// Time allowed for the pulled-up pin to rise before it is watched, in ns.
`define DPPC_SETTLE_NS 1000
// Least time a low level must persist to count as overcurrent, in ns.
`define DPPC_FILTER_NS 100
// Least times round up to whole cycles.
`define DPPC_SETTLE_CYC ((`DPPC_SETTLE_NS + `DPPC_CLK_PERIOD_NS - 1) / `DPPC_CLK_PERIOD_NS)
`define DPPC_FILTER_CYC ((`DPPC_FILTER_NS + `DPPC_CLK_PERIOD_NS - 1) / `DPPC_CLK_PERIOD_NS)
// Number of managed downstream ports (ports 3 and 4).
`define DPPC_NPORTS 2
// Index of port 3 in the per-port arrays.
`define DPPC_PORT3_IDX 0
// Index of port 4 in the per-port arrays.
`define DPPC_PORT4_IDX 1
// Reset value of the pin output enable (low means driving).
`define DPPC_OE_N_RST 1'b0
// Reset value of the internal pull-up enable.
`define DPPC_PU_RST 1'b0

`endif

// ---- common/dppc_pkg.sv ----
// Types shared by the downstream port power control design.
// Assumes nothing of its surroundings.
package dppc_pkg;

   // Life cycle of one power-control pin.
   typedef enum logic [1:0] {
      DPPC_DRIVE_LOW = 2'b00,  // Port off: pin is an output held low.
      DPPC_SETTLE    = 2'b01,  // Pin released, pull-up still charging.
      DPPC_MONITOR   = 2'b10   // Pin released and watched for overcurrent.
   } dppc_pin_state_t;

endpackage : dppc_pkg

// ---- rtl/dppc_port_pin.sv ----
// One power-enable / overcurrent-sense pin of a downstream port.
// Assumes the pin input is synchronous to clk_i and a pad resolves oe_n and pu.
`timescale 1ns/100ps
`include "dppc_params.svh"

module dppc_port_pin #(
   parameter int SETTLE_CYC = `DPPC_SETTLE_CYC,  // Cycles before the pin is watched.
   parameter int FILTER_CYC = `DPPC_FILTER_CYC   // Consecutive low cycles for overcurrent.
) (
   input  wire logic clk_i,       // Core clock.
   input  wire logic rstn_i,      // Synchronous reset, active low.
   input  wire logic enable_i,    // Port enabled by configuration and host.
   input  wire logic pin_i,       // Sampled pin level.
   input  wire logic oc_ack_i,    // Acknowledge of the overcurrent flag.
   output logic      pin_o,       // Value driven when the pin is an output.
   output logic      pin_oe_n_o,  // Low while the pin is driven.
   output logic      pin_pu_o,    // Internal pull-up enable.
   output logic      powered_o,   // Pin currently grants power.
   output logic      oc_flag_o    // Latched overcurrent indication.
);

   localparam int CW = $clog2(SETTLE_CYC + FILTER_CYC + 1);

   dppc_pkg::dppc_pin_state_t state;     // Pin life-cycle state.
   logic [CW-1:0]             settle_cnt; // Cycles spent settling.
   logic [CW-1:0]             low_cnt;    // Consecutive low samples.
   logic                      watch;      // Pin is watched and low this cycle.
   logic                      oc_hit;     // Overcurrent seen this cycle.

   assign watch  = (state == dppc_pkg::DPPC_MONITOR) && enable_i && !pin_i;
   assign oc_hit = watch && (low_cnt == CW'(FILTER_CYC - 1));

   ////////////////////////////////////////////////////////////////////////
   // Pin direction: released with pull-up while enabled, else driven low.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pin_oe_n_o <= `DPPC_OE_N_RST;
         pin_pu_o   <= `DPPC_PU_RST;
         pin_o      <= 1'b0;
         powered_o  <= 1'b0;
      end else begin
         pin_oe_n_o <= enable_i;
         pin_pu_o   <= enable_i;
         pin_o      <= 1'b0;
         powered_o  <= enable_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State machine. The settle phase keeps the slow pull-up rise from
   // being mistaken for an overcurrent low right after release.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state      <= dppc_pkg::DPPC_DRIVE_LOW;
         settle_cnt <= '0;
      end else begin
         case (state)
            dppc_pkg::DPPC_DRIVE_LOW: begin
               settle_cnt <= '0;
               if (enable_i) begin
                  state <= dppc_pkg::DPPC_SETTLE;
               end
            end
            dppc_pkg::DPPC_SETTLE: begin
               settle_cnt <= settle_cnt + CW'(1);
               if (!enable_i) begin
                  state <= dppc_pkg::DPPC_DRIVE_LOW;
               end else if (settle_cnt == CW'(SETTLE_CYC - 1)) begin
                  state <= dppc_pkg::DPPC_MONITOR;
               end
            end
            dppc_pkg::DPPC_MONITOR: begin
               if (!enable_i) begin
                  state <= dppc_pkg::DPPC_DRIVE_LOW;
               end
            end
            default: begin
               state <= dppc_pkg::DPPC_DRIVE_LOW;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Glitch filter on the low level, then a sticky flag; set beats ack.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         low_cnt   <= '0;
         oc_flag_o <= 1'b0;
      end else begin
         low_cnt <= (watch && !oc_hit) ? low_cnt + CW'(1) : '0;
         if (oc_hit) begin
            oc_flag_o <= 1'b1;
         end else if (oc_ack_i) begin
            oc_flag_o <= 1'b0;
         end
      end
   end

   // A fresh run of watched lows: the filter count starts from zero here,
   // because a cycle that is not watched has just cleared it.
   sequence s_fresh_low_run;
      !watch ##1 watch [*4];
   endsequence

   // Four fresh watched lows raise the flag on the next edge, even
   // against an acknowledge, since the set wins.
   a_oc_catch: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      s_fresh_low_run |=> oc_flag_o)
      else $error("Filtered overcurrent low was not latched.");

endmodule : dppc_port_pin

// ---- rtl/dppc_power_ctl.sv ----
// Downstream power control for hub ports 3 and 4 and the split port 3.
// Assumes hub control logic supplies enables and acks on the core clock.
//
// How it works
// - Enabled port: pin input with pull-up.
// - Enabled port: low pin means overcurrent.
// - Disabled port: pin output driven low.
// - Split off: pin powers both halves.
// - Split on: port 3 SuperSpeed enable follows its request.
`timescale 1ns/100ps
`include "dppc_params.svh"

module dppc_power_ctl #(
   parameter int SETTLE_CYC = `DPPC_SETTLE_CYC,  // Pull-up settle cycles.
   parameter int FILTER_CYC = `DPPC_FILTER_CYC   // Overcurrent filter cycles.
) (
   input  wire logic clk_i,                        // Core clock, 40 MHz.
   input  wire logic rstn_i,                       // Synchronous reset, active low.
   input  wire logic cfg_port3_en_i,               // Port 3 enabled by configuration.
   input  wire logic cfg_port4_en_i,               // Port 4 enabled by configuration.
   input  wire logic host_port3_power_i,           // Host has powered port 3.
   input  wire logic host_port4_power_i,           // Host has powered port 4.
   input  wire logic split_port_mode_i,            // Port 3 halves run separately.
   input  wire logic port3_ss_req_i,               // Power request for port 3 SS half.
   input  wire logic port3_oc_ack_i,               // Clears the port 3 flag.
   input  wire logic port4_oc_ack_i,               // Clears the port 4 flag.
   input  wire logic port3_power_ctl_i,            // Port 3 pin level.
   output logic      port3_power_ctl_o,            // Port 3 pin drive value.
   output logic      port3_power_ctl_oe_n_o,       // Port 3 pin drive, low active.
   output logic      port3_power_ctl_pu_o,         // Port 3 pull-up enable.
   input  wire logic port4_power_ctl_i,            // Port 4 pin level.
   output logic      port4_power_ctl_o,            // Port 4 pin drive value.
   output logic      port4_power_ctl_oe_n_o,       // Port 4 pin drive, low active.
   output logic      port4_power_ctl_pu_o,         // Port 4 pull-up enable.
   output logic      port3_superspeed_power_en_o,  // Port 3 SS half power, high active.
   output logic      port3_usb2_powered_o,         // Port 3 USB 2.0 half has power.
   output logic      port3_ss_powered_o,           // Port 3 SS half has power.
   output logic      port4_usb2_powered_o,         // Port 4 USB 2.0 half has power.
   output logic      port4_ss_powered_o,           // Port 4 SS half has power.
   output logic      port3_oc_flag_o,              // Port 3 overcurrent latched.
   output logic      port4_oc_flag_o               // Port 4 overcurrent latched.
);

   localparam int NP = `DPPC_NPORTS;
   localparam int P3 = `DPPC_PORT3_IDX;
   localparam int P4 = `DPPC_PORT4_IDX;

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks: counters need at least one cycle each.
   if (SETTLE_CYC < 1 || FILTER_CYC < 1) begin : g_bad_param
      $error("SETTLE_CYC and FILTER_CYC must be at least one.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port views of the scalar ports, so one loop serves both pins.
   // The ports stay separate scalars outside, so board wiring reads
   // naturally; the vectors only exist to feed the generate loop.
   logic [NP-1:0] port_en;   // Configuration and host both allow power.
   logic [NP-1:0] pin_in;    // Sampled pin levels.
   logic [NP-1:0] oc_ack;    // Flag acknowledges.
   logic [NP-1:0] pin_out;   // Pin drive values.
   logic [NP-1:0] pin_oe_n;  // Pin drive enables, low active.
   logic [NP-1:0] pin_pu;    // Pull-up enables.
   logic [NP-1:0] powered;   // Pin grants power.
   logic [NP-1:0] oc_flag;   // Latched overcurrent flags.

   // Either configuration or the host may switch a port off.
   assign port_en[P3] = cfg_port3_en_i & host_port3_power_i;
   assign port_en[P4] = cfg_port4_en_i & host_port4_power_i;
   assign pin_in[P3]  = port3_power_ctl_i;
   assign pin_in[P4]  = port4_power_ctl_i;
   assign oc_ack[P3]  = port3_oc_ack_i;
   assign oc_ack[P4]  = port4_oc_ack_i;

   ////////////////////////////////////////////////////////////////////////
   // One pin controller per port.
   for (genvar p = 0; p < NP; p++) begin : g_port
      dppc_port_pin #(
         .SETTLE_CYC (SETTLE_CYC),
         .FILTER_CYC (FILTER_CYC)
      ) u_pin (
         .clk_i      (clk_i),
         .rstn_i     (rstn_i),
         .enable_i   (port_en[p]),
         .pin_i      (pin_in[p]),
         .oc_ack_i   (oc_ack[p]),
         .pin_o      (pin_out[p]),
         .pin_oe_n_o (pin_oe_n[p]),
         .pin_pu_o   (pin_pu[p]),
         .powered_o  (powered[p]),
         .oc_flag_o  (oc_flag[p])
      );

      // An enabled port has its pin released with the pull-up on.
      a_pin_released: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         port_en[p] |=> pin_oe_n[p] && pin_pu[p])
         else $error("Enabled port pin is not a pulled-up input.");

      // A disabled port has its pin driven low without pull-up.
      a_pin_drives_low: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         !port_en[p] |=> !pin_oe_n[p] && !pin_out[p] && !pin_pu[p])
         else $error("Disabled port pin is not driven low.");

      // A new flag only appears on a port that was enabled.
      a_oc_only_enabled: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         $rose(oc_flag[p]) |-> $past(port_en[p]) && !$past(pin_in[p]))
         else $error("Overcurrent flag rose without an enabled low pin.");

      // The flag stays until it is acknowledged.
      a_oc_held: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         oc_flag[p] && !oc_ack[p] |=> oc_flag[p])
         else $error("Overcurrent flag dropped without acknowledge.");

      // Acknowledge with no overcurrent low in the same cycle clears the flag.
      a_oc_cleared: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         oc_flag[p] && oc_ack[p] && !(port_en[p] && !pin_in[p]) |=> !oc_flag[p])
         else $error("Acknowledged overcurrent flag did not clear.");

      // The power status mirrors the enable one cycle late, both ways.
      // Hub logic reads this, not the pin, so it must never run ahead.
      a_power_follows: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         ##1 powered[p] == $past(port_en[p]))
         else $error("Power status does not follow the port enable.");

      // A disabled port drives its own pin low, which must never read
      // back as an overcurrent and raise a new flag.
      a_oc_quiet_off: assert property (
         @(posedge clk_i) disable iff (!rstn_i)
         !port_en[p] && !oc_flag[p] |=> !oc_flag[p])
         else $error("Overcurrent flag rose on a disabled port.");
   end

   assign port3_power_ctl_o      = pin_out[P3];
   assign port3_power_ctl_oe_n_o = pin_oe_n[P3];
   assign port3_power_ctl_pu_o   = pin_pu[P3];
   assign port4_power_ctl_o      = pin_out[P4];
   assign port4_power_ctl_oe_n_o = pin_oe_n[P4];
   assign port4_power_ctl_pu_o   = pin_pu[P4];
   assign port3_usb2_powered_o   = powered[P3];
   assign port4_usb2_powered_o   = powered[P4];
   assign port3_oc_flag_o        = oc_flag[P3];
   assign port4_oc_flag_o        = oc_flag[P4];

   ////////////////////////////////////////////////////////////////////////
   // SuperSpeed half of port 3. In split mode the pin covers only the
   // USB 2.0 half and the dedicated enable powers the SuperSpeed half.
   // That enable is meant for an embedded device only; it has no
   // overcurrent sense, so a user-reachable connector would be unguarded.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         port3_superspeed_power_en_o <= 1'b0;
         port3_ss_powered_o          <= 1'b0;
      end else if (split_port_mode_i) begin
         port3_superspeed_power_en_o <= port3_ss_req_i;
         port3_ss_powered_o          <= port3_ss_req_i;
      end else begin
         port3_superspeed_power_en_o <= 1'b0;
         port3_ss_powered_o          <= port_en[P3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port 4 has no split option: its pin always powers both halves.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         port4_ss_powered_o <= 1'b0;
      end else begin
         port4_ss_powered_o <= port_en[P4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port 3 SuperSpeed behaviour with split on and off, and port 4 behaviour, written as short sequences of cause and effect.
   sequence s_split_ss_on;
      split_port_mode_i && port3_ss_req_i;
   endsequence

   sequence s_combined_on;
      !split_port_mode_i && port_en[P3];
   endsequence

   a_ss_split_on: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      s_split_ss_on |=> port3_superspeed_power_en_o && port3_ss_powered_o)
      else $error("Split mode request did not raise the SS enable.");

   a_ss_split_off: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      !split_port_mode_i |=> !port3_superspeed_power_en_o)
      else $error("SS enable high outside split mode.");

   a_ss_follows_pin: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      s_combined_on |=> port3_ss_powered_o && port3_usb2_powered_o && port3_power_ctl_pu_o)
      else $error("Combined port 3 halves disagree with the pin.");

   a_ss_split_indep: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      split_port_mode_i && !port3_ss_req_i && port_en[P3]
      |=> !port3_ss_powered_o && port3_usb2_powered_o)
      else $error("Split port 3 SS half did not separate from the pin.");

   // In split mode the SuperSpeed half stays on while the pin is off.
   a_ss_split_alone: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      split_port_mode_i && port3_ss_req_i && !port_en[P3]
      |=> port3_superspeed_power_en_o && !port3_usb2_powered_o)
      else $error("Split port 3 SS half followed the disabled pin.");

   a_port4_both: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ##1 port4_ss_powered_o == port4_usb2_powered_o)
      else $error("Port 4 halves disagree.");

endmodule : dppc_power_ctl

// ---- tb/dppc_port_partner.sv ----
// Behavioural model of the external power switch and current monitor on one pin.
// Assumes the device splits the pin into drive, drive enable (low active) and pull-up.
`timescale 1ns/100ps

module dppc_port_partner (
   input  wire logic drive_i,       // Value the device drives.
   input  wire logic oe_n_i,        // Low while the device drives the pin.
   input  wire logic pu_i,          // Device pull-up enable.
   input  wire logic fault_i,       // Bench commands an overcurrent.
   input  wire logic ss_en_i,       // SuperSpeed half enable from the device.
   output logic      pin_level_o,   // Resolved wire level fed back to the device.
   output logic      vbus_on_o,     // Power switch state.
   output logic      embedded_on_o  // Embedded SuperSpeed device powered.
);
   ////////////////////////////////////////////////////////////
   // The monitor can only pull low; the pull-up lifts the wire, and so does an undriven wire with drive low.
   always_comb begin
      if (!oe_n_i) begin
         pin_level_o = drive_i;  // Device output wins the wire.
      end else if (fault_i) begin
         pin_level_o = 1'h0;  // Active low overcurrent report.
      end else if (pu_i) begin
         pin_level_o = 1'h1;  // Pull-up level turns the switch on.
      end else begin
         // Nothing holds the wire, so show the inverse of the device drive value.
         pin_level_o = ~drive_i;
      end
   end

   // The switch powers the port from the wire level.
   assign vbus_on_o = pin_level_o;

   // Only an embedded device sits behind the SuperSpeed enable.
   assign embedded_on_o = ss_en_i;
endmodule : dppc_port_partner

// ---- tb/dppc_power_ctl_tb.sv ----
// Self-checking bench for the downstream port power control block.
// Assumes the design carries its own assertions and one partner model per pin.
`timescale 1ns/100ps

module dppc_power_ctl_tb;
   localparam int SETTLE = 4;  // Short settle keeps the run brief.
   localparam int FILTER = 4;  // Filter length the design's checks expect.

   logic clk_i, rstn_i, cfg3, cfg4, host3, host4, split, ss_req;  // Bench drives.
   logic ack3, ack4, fault3, fault4;                              // Bench drives.
   logic lvl3, lvl4, drv3, oe3, pu3, drv4, oe4, pu4, ss_en;       // Pin side.
   logic u2p3, ssp3, u2p4, ssp4, flag3, flag4, vbus3, vbus4;      // Status side.
   int   num_errors = 0;  // Mismatches seen.
   int   checked    = 0;  // Comparisons made.

   ////////////////////////////////////////////////////////////
   // Device under test and the far side of both pins.
   dppc_power_ctl #(.SETTLE_CYC(SETTLE), .FILTER_CYC(FILTER)) i_dppc_power_ctl (
      .clk_i(clk_i), .rstn_i(rstn_i), .cfg_port3_en_i(cfg3), .cfg_port4_en_i(cfg4),
      .host_port3_power_i(host3), .host_port4_power_i(host4),
      .split_port_mode_i(split), .port3_ss_req_i(ss_req),
      .port3_oc_ack_i(ack3), .port4_oc_ack_i(ack4),
      .port3_power_ctl_i(lvl3), .port3_power_ctl_o(drv3),
      .port3_power_ctl_oe_n_o(oe3), .port3_power_ctl_pu_o(pu3),
      .port4_power_ctl_i(lvl4), .port4_power_ctl_o(drv4),
      .port4_power_ctl_oe_n_o(oe4), .port4_power_ctl_pu_o(pu4),
      .port3_superspeed_power_en_o(ss_en), .port3_usb2_powered_o(u2p3),
      .port3_ss_powered_o(ssp3), .port4_usb2_powered_o(u2p4),
      .port4_ss_powered_o(ssp4), .port3_oc_flag_o(flag3), .port4_oc_flag_o(flag4));

   dppc_port_partner i_dppc_port_partner_3 (.drive_i(drv3), .oe_n_i(oe3), .pu_i(pu3),
      .fault_i(fault3), .ss_en_i(ss_en), .pin_level_o(lvl3), .vbus_on_o(vbus3),
      .embedded_on_o());
   dppc_port_partner i_dppc_port_partner_4 (.drive_i(drv4), .oe_n_i(oe4), .pu_i(pu4),
      .fault_i(fault4), .ss_en_i(1'h0), .pin_level_o(lvl4), .vbus_on_o(vbus4),
      .embedded_on_o());

   ////////////////////////////////////////////////////////////
   // 40 MHz core clock.
   initial clk_i = 1'h0;
   always #12.5 clk_i = ~clk_i;

   // Moves past n rising edges, then off the edge so updates have landed.
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : step

   // Compares one output bit; unknowns never pass.
   task automatic chk(input logic seen, input logic exp, input string msg);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s seen %b expected %b", $time, msg, seen, exp);
      end
   endtask : chk

   // Prints counts and the verdict, then stops.
   task automatic print_verdict;
      $display("Errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////
   // Power needs config and host together; split off leaves the SS request unused.
   task automatic t_enable;
      ss_req = 1'h1;
      cfg3   = 1'h1;
      step(2);
      chk(oe3, 1'h0, "cfg only still drives");
      chk(vbus3, 1'h0, "cfg only no power");
      host3 = 1'h1;
      step(1);
      chk(oe3, 1'h1, "enabled pin released");
      chk(pu3, 1'h1, "enabled pull-up on");
      chk(vbus3, 1'h1, "pull-up powers port");
      chk(ssp3, 1'h1, "ss half follows pin");
      chk(ss_en, 1'h0, "ss enable unused");
      host3 = 1'h0;
      step(1);
      chk(oe3, 1'h0, "host off drives");
      chk(drv3, 1'h0, "host off drives low");
      chk(ssp3, 1'h0, "ss half off with pin");
   endtask : t_enable

   // Short lows are filtered, a real one latches until acknowledged.
   task automatic t_oc;
      int n;
      cfg4  = 1'h1;
      host4 = 1'h1;
      step(SETTLE + 3);
      chk(pu4, 1'h1, "port 4 pull-up on");
      chk(vbus4, 1'h1, "port 4 powered");
      fault4 = 1'h1;
      step(FILTER - 1);
      fault4 = 1'h0;
      step(2);
      chk(flag4, 1'h0, "short low ignored");
      fault4 = 1'h1;
      n      = 0;
      while (flag4 !== 1'h1 && n < 8) begin
         step(1);
         n++;
      end
      chk(flag4, 1'h1, "overcurrent caught");
      chk(n == FILTER, 1'h1, "overcurrent delay");
      fault4 = 1'h0;
      step(4);
      chk(flag4, 1'h1, "flag held");
      ack4 = 1'h1;
      step(1);
      ack4 = 1'h0;
      step(1);
      chk(flag4, 1'h0, "flag cleared by ack");
      cfg4 = 1'h0;
      step(1);
      chk(oe4, 1'h0, "config off drives");
      chk(drv4, 1'h0, "config off drives low");
      chk(pu4, 1'h0, "config off pull-up off");
      step(FILTER + 3);
      chk(flag4, 1'h0, "own low is no overcurrent");
      host4 = 1'h0;
   endtask : t_oc

   // Split mode hands port 3's SS half to its own enable; port 4 stays combined.
   task automatic t_split;
      split = 1'h1;
      cfg3  = 1'h1;
      host3 = 1'h1;
      cfg4  = 1'h1;
      host4 = 1'h1;
      step(1);
      chk(ss_en, 1'h1, "ss enable high");
      chk(ssp3, 1'h1, "ss half powered");
      chk(u2p3, 1'h1, "usb2 half powered");
      chk(ssp4, 1'h1, "port 4 combined");
      chk(u2p4, 1'h1, "port 4 usb2");
      ss_req = 1'h0;
      step(1);
      chk(ss_en, 1'h0, "ss request dropped");
      chk(ssp3, 1'h0, "ss half off alone");
      chk(u2p3, 1'h1, "usb2 half stays");
      ss_req = 1'h1;
      step(SETTLE + 2);
      fault3 = 1'h1;
      step(FILTER);
      chk(flag3, 1'h1, "port 3 overcurrent");
      chk(ss_en, 1'h1, "ss ignores pin fault");
      fault3 = 1'h0;
      ack3   = 1'h1;
      host3  = 1'h0;
      step(1);
      chk(flag3, 1'h0, "port 3 flag cleared");
      chk(ss_en, 1'h1, "ss apart from pin");
      chk(u2p3, 1'h0, "usb2 half off");
      ack3   = 1'h0;
      split  = 1'h0;
      ss_req = 1'h1;
      step(1);
      chk(ss_en, 1'h0, "ss unused split off");
      chk(ssp3, 1'h0, "ss follows disabled pin");
   endtask : t_split

   ////////////////////////////////////////////////////////////
   // Main sequence: reset for two cycles, then the scenarios.
   initial begin
      {rstn_i, cfg3, cfg4, host3, host4, split, ss_req} = 7'h00;
      {ack3, ack4, fault3, fault4} = 4'h0;
      step(1);
      chk(oe3, 1'h0, "reset drives pin");
      chk(pu3, 1'h0, "reset pull-up off");
      step(1);
      rstn_i = 1'h1;
      step(1);
      t_enable();
      t_oc();
      t_split();
      print_verdict();
   end

   // Watchdog well beyond the fifty or so cycles the scenarios need.
   initial begin
      #(25 * 3000);
      num_errors++;
      print_verdict();
   end
endmodule : dppc_power_ctl_tb
